// >>> bsfu_defines.svh
// Bit positions, widths and reset values for the bit, shift and flag unit.
`ifndef BSFU_DEFINES_SVH
`define BSFU_DEFINES_SVH

// ----------------------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------------------
`define BSFU_FLAG_C 0
`define BSFU_FLAG_Z 1
`define BSFU_FLAG_N 2
`define BSFU_FLAG_V 3
`define BSFU_FLAG_T 6

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define BSFU_IO_ADDR_W 6
`define BSFU_STATUS_RESET 8'h00
`define BSFU_BYTE_RESET 8'h00
`define BSFU_IO_ADDR_RESET 6'h00

`endif

// >>> bsfu_pkg.sv
// Types shared by the bit, shift and flag unit and its shifter.
package bsfu_pkg;

  // --------------------------------------------------------------------------
  // Operations accepted from the instruction decoder
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    BSFU_OP_IDLE,
    BSFU_OP_IO_BIT_SET,
    BSFU_OP_IO_BIT_CLEAR,
    BSFU_OP_LOGICAL_LEFT_SHIFT,
    BSFU_OP_LOGICAL_RIGHT_SHIFT,
    BSFU_OP_ROTATE_LEFT_CARRY,
    BSFU_OP_ROTATE_RIGHT_CARRY,
    BSFU_OP_ARITH_RIGHT_SHIFT,
    BSFU_OP_NIBBLE_SWAP,
    BSFU_OP_STATUS_FLAG_SET,
    BSFU_OP_STATUS_FLAG_CLEAR,
    BSFU_OP_BIT_STORE_TO_FLAG,
    BSFU_OP_FLAG_TO_BIT_LOAD,
    BSFU_OP_CARRY_SET,
    BSFU_OP_CARRY_CLEAR,
    BSFU_OP_NEGATIVE_SET,
    BSFU_OP_NEGATIVE_CLEAR,
    BSFU_OP_ZERO_SET,
    BSFU_OP_ZERO_CLEAR,
    BSFU_OP_POP
  } bsfu_op_type;

  // --------------------------------------------------------------------------
  // Kinds of move done by the shifter
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    BSFU_SH_PASS,
    BSFU_SH_LSL,
    BSFU_SH_LSR,
    BSFU_SH_ROL,
    BSFU_SH_ROR,
    BSFU_SH_ASR,
    BSFU_SH_SWAP
  } bsfu_shift_type;

endpackage

// >>> bsfu_shift_if.sv
// Signals between the unit and its shifter.
`timescale 1ns/1ns
interface bsfu_shift_if;
  bsfu_pkg::bsfu_shift_type kind;
  logic [7:0]               operand;
  logic                     carry_in;
  logic [7:0]               result;
  logic                     carry_out;
  logic                     zero_out;
  logic                     neg_out;
  logic                     ovf_out;

  modport core (
    output kind,
    output operand,
    output carry_in,
    input  result,
    input  carry_out,
    input  zero_out,
    input  neg_out,
    input  ovf_out
  );

  modport unit (
    input  kind,
    input  operand,
    input  carry_in,
    output result,
    output carry_out,
    output zero_out,
    output neg_out,
    output ovf_out
  );
endinterface

// >>> bsfu_shifter.sv
// Combinational shifter, rotator and nibble swapper with flag results.
`timescale 1ns/1ns
module bsfu_shifter (
  bsfu_shift_if.unit bus
);

  // --------------------------------------------------------------------------
  // Result and carry
  // --------------------------------------------------------------------------
  always_comb begin
    bus.result    = bus.operand;
    bus.carry_out = bus.carry_in;
    case (bus.kind)
      bsfu_pkg::BSFU_SH_LSL: begin
        bus.result    = {bus.operand[6:0], 1'b0}; // [RULE3]
        bus.carry_out = bus.operand[7];
      end
      bsfu_pkg::BSFU_SH_LSR: begin
        bus.result    = {1'b0, bus.operand[7:1]}; // [RULE4]
        bus.carry_out = bus.operand[0];
      end
      bsfu_pkg::BSFU_SH_ROL: begin
        bus.result    = {bus.operand[6:0], bus.carry_in}; // [RULE5]
        bus.carry_out = bus.operand[7]; // [RULE5]
      end
      bsfu_pkg::BSFU_SH_ROR: begin
        bus.result    = {bus.carry_in, bus.operand[7:1]}; // [RULE6]
        bus.carry_out = bus.operand[0]; // [RULE6]
      end
      bsfu_pkg::BSFU_SH_ASR: begin
        bus.result    = {bus.operand[7], bus.operand[7:1]}; // [RULE7]
        bus.carry_out = bus.operand[0];
      end
      bsfu_pkg::BSFU_SH_SWAP: begin
        bus.result = {bus.operand[3:0], bus.operand[7:4]}; // [RULE8]
      end
      default: begin
        bus.result    = bus.operand;
        bus.carry_out = bus.carry_in;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Flags from the result
  // --------------------------------------------------------------------------
  assign bus.zero_out = (bus.result == 8'h00); // [RULE17]
  assign bus.neg_out  = bus.result[7]; // [RULE17]
  assign bus.ovf_out  = bus.result[7] ^ bus.carry_out; // [RULE17]

endmodule // bsfu_shifter

// >>> bsfu_unit.sv
// Execution unit for bit, shift, rotate, flag and pop operations.
//
// Contract
// [RULE1] I/O bit set forces the selected bit to one, others kept.
// [RULE2] I/O bit clear forces the selected bit to zero, others kept.
// [RULE3] Logical left shift moves bits up, bit 0 gets zero.
// [RULE4] Logical right shift moves bits down, bit 7 gets zero.
// [RULE5] Rotate left: bit 0 gets old carry, carry gets old bit 7.
// [RULE6] Rotate right: bit 7 gets old carry, carry gets old bit 0.
// [RULE7] Arithmetic right shift moves bits down and keeps bit 7.
// [RULE8] Nibble swap exchanges the low and high four bits at once.
// [RULE9] Status flag set writes one into the selected status bit only.
// [RULE10] Status flag clear writes zero into the selected status bit only.
// [RULE11] Bit store copies the selected source bit into the transfer flag.
// [RULE12] Bit load copies the transfer flag into the selected destination bit.
// [RULE13] Carry set forces carry to one; carry clear forces it to zero.
// [RULE14] Negative set forces negative to one; negative clear to zero.
// [RULE15] Zero set forces zero flag to one; zero clear to zero.
// [RULE16] Pop loads the destination with the byte from the stack top.
// [RULE17] Shifts and rotates update zero, carry, negative and overflow flags.
// [RULE18] Single-flag operations change only their flag, no general register.
`timescale 1ns/1ns
`include "bsfu_defines.svh"
module bsfu_unit (
  input  logic                          clock_in,
  input  logic                          reset_in,
  input  logic                          op_valid_in,
  input  bsfu_pkg::bsfu_op_type         op_code_in,
  input  logic [2:0]                    bit_sel_in,
  input  logic [7:0]                    rd_value_in,
  input  logic [7:0]                    rr_value_in,
  input  logic [`BSFU_IO_ADDR_W-1:0]    io_addr_in,
  input  logic [7:0]                    io_value_in,
  input  logic [7:0]                    stack_byte_in,
  input  logic                          status_load_in,
  input  logic [7:0]                    status_value_in,
  output logic [7:0]                    rd_result_out,
  output logic                          rd_write_out,
  output logic [`BSFU_IO_ADDR_W-1:0]    io_addr_out,
  output logic [7:0]                    io_result_out,
  output logic                          io_write_out,
  output logic [7:0]                    status_out,
  output logic                          done_out
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [7:0]                 rd_result_q;
  logic [7:0]                 rd_result_d;
  logic                       rd_write_q;
  logic                       rd_write_d;
  logic [`BSFU_IO_ADDR_W-1:0] io_addr_q;
  logic [`BSFU_IO_ADDR_W-1:0] io_addr_d;
  logic [7:0]                 io_result_q;
  logic [7:0]                 io_result_d;
  logic                       io_write_q;
  logic                       io_write_d;
  logic [7:0]                 status_q;
  logic [7:0]                 status_d;
  logic                       done_q;
  logic                       done_d;
  logic [7:0]                 bit_mask_w;
  logic                       rr_bit_w;
  logic                       carry_w;
  logic                       transfer_w;
  logic                       shift_op_w;

  bsfu_shift_if shift_bus ();

  bsfu_shifter u_shifter (
    .bus (shift_bus.unit)
  );

  assign bit_mask_w = 8'h01 << bit_sel_in;
  assign rr_bit_w   = rr_value_in[bit_sel_in];
  assign carry_w    = status_q[`BSFU_FLAG_C];
  assign transfer_w = status_q[`BSFU_FLAG_T];

  // --------------------------------------------------------------------------
  // Shifter control
  // --------------------------------------------------------------------------
  always_comb begin
    shift_bus.kind = bsfu_pkg::BSFU_SH_PASS;
    shift_op_w     = 1'b1;
    case (op_code_in)
      bsfu_pkg::BSFU_OP_LOGICAL_LEFT_SHIFT:  shift_bus.kind = bsfu_pkg::BSFU_SH_LSL;
      bsfu_pkg::BSFU_OP_LOGICAL_RIGHT_SHIFT: shift_bus.kind = bsfu_pkg::BSFU_SH_LSR;
      bsfu_pkg::BSFU_OP_ROTATE_LEFT_CARRY:   shift_bus.kind = bsfu_pkg::BSFU_SH_ROL;
      bsfu_pkg::BSFU_OP_ROTATE_RIGHT_CARRY:  shift_bus.kind = bsfu_pkg::BSFU_SH_ROR;
      bsfu_pkg::BSFU_OP_ARITH_RIGHT_SHIFT:   shift_bus.kind = bsfu_pkg::BSFU_SH_ASR;
      bsfu_pkg::BSFU_OP_NIBBLE_SWAP: begin
        shift_bus.kind = bsfu_pkg::BSFU_SH_SWAP;
        shift_op_w     = 1'b0;
      end
      default: shift_op_w = 1'b0;
    endcase
  end

  assign shift_bus.operand  = rd_value_in;
  assign shift_bus.carry_in = carry_w;

  // --------------------------------------------------------------------------
  // Next values
  // --------------------------------------------------------------------------
  // A status load from another instruction group is applied first, so an
  // operation in the same cycle modifies the freshly loaded flags.
  always_comb begin
    rd_result_d = rd_result_q;
    rd_write_d  = 1'b0;
    io_addr_d   = io_addr_q;
    io_result_d = io_result_q;
    io_write_d  = 1'b0;
    status_d    = status_load_in ? status_value_in : status_q;
    done_d      = op_valid_in;
    if (op_valid_in) begin
      case (op_code_in)
        bsfu_pkg::BSFU_OP_IO_BIT_SET: begin
          io_result_d = io_value_in | bit_mask_w; // [RULE1]
          io_addr_d   = io_addr_in;
          io_write_d  = 1'b1;
        end
        bsfu_pkg::BSFU_OP_IO_BIT_CLEAR: begin
          io_result_d = io_value_in & ~bit_mask_w; // [RULE2]
          io_addr_d   = io_addr_in;
          io_write_d  = 1'b1;
        end
        bsfu_pkg::BSFU_OP_LOGICAL_LEFT_SHIFT,
        bsfu_pkg::BSFU_OP_LOGICAL_RIGHT_SHIFT,
        bsfu_pkg::BSFU_OP_ROTATE_LEFT_CARRY,
        bsfu_pkg::BSFU_OP_ROTATE_RIGHT_CARRY,
        bsfu_pkg::BSFU_OP_ARITH_RIGHT_SHIFT: begin
          rd_result_d            = shift_bus.result;
          rd_write_d             = 1'b1;
          status_d[`BSFU_FLAG_C] = shift_bus.carry_out; // [RULE17]
          status_d[`BSFU_FLAG_Z] = shift_bus.zero_out; // [RULE17]
          status_d[`BSFU_FLAG_N] = shift_bus.neg_out; // [RULE17]
          status_d[`BSFU_FLAG_V] = shift_bus.ovf_out; // [RULE17]
        end
        bsfu_pkg::BSFU_OP_NIBBLE_SWAP: begin
          rd_result_d = shift_bus.result; // [RULE8]
          rd_write_d  = 1'b1;
        end
        bsfu_pkg::BSFU_OP_STATUS_FLAG_SET: status_d = status_d | bit_mask_w; // [RULE9]
        bsfu_pkg::BSFU_OP_STATUS_FLAG_CLEAR: status_d = status_d & ~bit_mask_w; // [RULE10]
        bsfu_pkg::BSFU_OP_BIT_STORE_TO_FLAG: status_d[`BSFU_FLAG_T] = rr_bit_w; // [RULE11]
        bsfu_pkg::BSFU_OP_FLAG_TO_BIT_LOAD: begin
          rd_result_d = transfer_w ? (rd_value_in | bit_mask_w) : (rd_value_in & ~bit_mask_w); // [RULE12]
          rd_write_d  = 1'b1;
        end
        bsfu_pkg::BSFU_OP_CARRY_SET: status_d[`BSFU_FLAG_C] = 1'b1; // [RULE13] [RULE18]
        bsfu_pkg::BSFU_OP_CARRY_CLEAR: status_d[`BSFU_FLAG_C] = 1'b0; // [RULE13] [RULE18]
        bsfu_pkg::BSFU_OP_NEGATIVE_SET: status_d[`BSFU_FLAG_N] = 1'b1; // [RULE14] [RULE18]
        bsfu_pkg::BSFU_OP_NEGATIVE_CLEAR: status_d[`BSFU_FLAG_N] = 1'b0; // [RULE14] [RULE18]
        bsfu_pkg::BSFU_OP_ZERO_SET: status_d[`BSFU_FLAG_Z] = 1'b1; // [RULE15] [RULE18]
        bsfu_pkg::BSFU_OP_ZERO_CLEAR: status_d[`BSFU_FLAG_Z] = 1'b0; // [RULE15] [RULE18]
        bsfu_pkg::BSFU_OP_POP: begin
          rd_result_d = stack_byte_in; // [RULE16]
          rd_write_d  = 1'b1;
        end
        default: done_d = 1'b0;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rd_result_q <= `BSFU_BYTE_RESET;
      rd_write_q  <= 1'b0;
      io_addr_q   <= `BSFU_IO_ADDR_RESET;
      io_result_q <= `BSFU_BYTE_RESET;
      io_write_q  <= 1'b0;
      status_q    <= `BSFU_STATUS_RESET;
      done_q      <= 1'b0;
    end else begin
      rd_result_q <= rd_result_d;
      rd_write_q  <= rd_write_d;
      io_addr_q   <= io_addr_d;
      io_result_q <= io_result_d;
      io_write_q  <= io_write_d;
      status_q    <= status_d;
      done_q      <= done_d;
    end
  end

  assign rd_result_out = rd_result_q;
  assign rd_write_out  = rd_write_q;
  assign io_addr_out   = io_addr_q;
  assign io_result_out = io_result_q;
  assign io_write_out  = io_write_q;
  assign status_out    = status_q;
  assign done_out      = done_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  sequence s_issue(bsfu_pkg::bsfu_op_type o);
    op_valid_in && !status_load_in && (op_code_in == o);
  endsequence

  sequence s_shift_issue;
    op_valid_in && !status_load_in && shift_op_w;
  endsequence

  chk_io_bit_set : assert property (s_issue(bsfu_pkg::BSFU_OP_IO_BIT_SET) |=> // [RULE1]
    io_write_out && (io_addr_out == $past(io_addr_in)) &&
    (io_result_out == ($past(io_value_in) | (8'h01 << $past(bit_sel_in)))))
    else $error("I/O bit set result wrong");

  chk_io_bit_clear : assert property (s_issue(bsfu_pkg::BSFU_OP_IO_BIT_CLEAR) |=> // [RULE2]
    io_write_out && (io_result_out == ($past(io_value_in) & ~(8'h01 << $past(bit_sel_in)))))
    else $error("I/O bit clear result wrong");

  chk_left_shift : assert property (s_issue(bsfu_pkg::BSFU_OP_LOGICAL_LEFT_SHIFT) |=> // [RULE3]
    rd_write_out && (rd_result_out == 8'($past(rd_value_in) << 1)))
    else $error("Logical left shift result wrong");

  chk_right_shift : assert property (s_issue(bsfu_pkg::BSFU_OP_LOGICAL_RIGHT_SHIFT) |=> // [RULE4]
    rd_write_out && (rd_result_out == ($past(rd_value_in) >> 1)))
    else $error("Logical right shift result wrong");

  chk_rotate_left : assert property (s_issue(bsfu_pkg::BSFU_OP_ROTATE_LEFT_CARRY) |=> // [RULE5]
    (rd_result_out == 8'({$past(rd_value_in), $past(carry_w)})) &&
    (status_out[`BSFU_FLAG_C] == $past(rd_value_in) >> 7))
    else $error("Rotate left through carry wrong");

  chk_rotate_right : assert property (s_issue(bsfu_pkg::BSFU_OP_ROTATE_RIGHT_CARRY) |=> // [RULE6]
    (rd_result_out == 8'({$past(carry_w), $past(rd_value_in)} >> 1)) &&
    (status_out[`BSFU_FLAG_C] == ($past(rd_value_in) & 8'h01)))
    else $error("Rotate right through carry wrong");

  chk_arith_shift : assert property (s_issue(bsfu_pkg::BSFU_OP_ARITH_RIGHT_SHIFT) |=> // [RULE7]
    rd_result_out == 8'($signed($past(rd_value_in)) >>> 1))
    else $error("Arithmetic right shift result wrong");

  chk_nibble_swap : assert property (s_issue(bsfu_pkg::BSFU_OP_NIBBLE_SWAP) |=> // [RULE8]
    rd_write_out && (rd_result_out == 8'({$past(rd_value_in), $past(rd_value_in)} >> 4)) &&
    $stable(status_out))
    else $error("Nibble swap result wrong");

  chk_flag_set : assert property (s_issue(bsfu_pkg::BSFU_OP_STATUS_FLAG_SET) |=> // [RULE9]
    status_out == ($past(status_q) | (8'h01 << $past(bit_sel_in))))
    else $error("Status flag set wrong");

  chk_flag_clear : assert property (s_issue(bsfu_pkg::BSFU_OP_STATUS_FLAG_CLEAR) |=> // [RULE10]
    status_out == ($past(status_q) & ~(8'h01 << $past(bit_sel_in))))
    else $error("Status flag clear wrong");

  chk_bit_store : assert property (s_issue(bsfu_pkg::BSFU_OP_BIT_STORE_TO_FLAG) |=> // [RULE11]
    status_out[`BSFU_FLAG_T] == $past(rr_bit_w))
    else $error("Bit store to transfer flag wrong");

  chk_bit_load : assert property (s_issue(bsfu_pkg::BSFU_OP_FLAG_TO_BIT_LOAD) |=> // [RULE12]
    rd_write_out && (rd_result_out[$past(bit_sel_in)] == $past(transfer_w)) &&
    ((rd_result_out ^ $past(rd_value_in)) & ~(8'h01 << $past(bit_sel_in))) == 8'h00)
    else $error("Flag to bit load wrong");

  chk_carry_ops : assert property (s_issue(bsfu_pkg::BSFU_OP_CARRY_SET) |=> // [RULE13]
    (status_out == ($past(status_q) | 8'h01)) && !rd_write_out && !io_write_out)
    else $error("Carry set changed more than carry");

  chk_negative_ops : assert property (s_issue(bsfu_pkg::BSFU_OP_NEGATIVE_CLEAR) |=> // [RULE14]
    (status_out == ($past(status_q) & 8'hFB)) && !rd_write_out)
    else $error("Negative clear changed more than negative");

  chk_zero_ops : assert property (s_issue(bsfu_pkg::BSFU_OP_ZERO_SET) |=> // [RULE15]
    (status_out == ($past(status_q) | 8'h02)) && !rd_write_out)
    else $error("Zero set changed more than zero");

  chk_pop_load : assert property (s_issue(bsfu_pkg::BSFU_OP_POP) |=> // [RULE16]
    rd_write_out && (rd_result_out == $past(stack_byte_in)) && $stable(status_out))
    else $error("Pop did not load the stack byte");

  chk_shift_flags : assert property (s_shift_issue |=> // [RULE17]
    (status_out[`BSFU_FLAG_Z] == (rd_result_out == 8'h00)) &&
    (status_out[`BSFU_FLAG_N] == rd_result_out[7]) &&
    (status_out[`BSFU_FLAG_V] == (status_out[`BSFU_FLAG_N] ^ status_out[`BSFU_FLAG_C])))
    else $error("Shift flags inconsistent with result");

  chk_flag_only : assert property (s_issue(bsfu_pkg::BSFU_OP_CARRY_CLEAR) |=> // [RULE18]
    !rd_write_out && !io_write_out && done_out && (status_out == ($past(status_q) & 8'hFE)))
    else $error("Carry clear touched a register");

  chk_negative_set : assert property (s_issue(bsfu_pkg::BSFU_OP_NEGATIVE_SET) |=> // [RULE14]
    (status_out == ($past(status_q) | 8'h04)) && !rd_write_out && !io_write_out)
    else $error("Negative set changed more than negative");

  chk_zero_clear : assert property (s_issue(bsfu_pkg::BSFU_OP_ZERO_CLEAR) |=> // [RULE15]
    (status_out == ($past(status_q) & 8'hFD)) && !rd_write_out && !io_write_out)
    else $error("Zero clear changed more than zero");

  chk_io_clear_addr : assert property (s_issue(bsfu_pkg::BSFU_OP_IO_BIT_CLEAR) |=> // [RULE2]
    (io_addr_out == $past(io_addr_in)) && !rd_write_out)
    else $error("I/O bit clear went to the wrong register");

endmodule // bsfu_unit

// >>> bsfu_core_model.sv
// Model of the register file and I/O space that receive the unit's write-backs.
`timescale 1ns/1ns
`include "bsfu_defines.svh"
module bsfu_core_model (
  input  logic                       clock_in,
  input  logic                       reset_in,
  input  logic                       preload_in,
  input  logic [7:0]                 preload_value_in,
  input  logic                       rd_write_in,
  input  logic [7:0]                 rd_result_in,
  input  logic                       io_write_in,
  input  logic [`BSFU_IO_ADDR_W-1:0] io_write_addr_in,
  input  logic [7:0]                 io_result_in,
  input  logic [`BSFU_IO_ADDR_W-1:0] io_read_addr_in,
  output logic [7:0]                 rd_value_out,
  output logic [7:0]                 io_value_out
);
  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  logic [7:0] io_q [64];

  // Each I/O register starts at a value of its own so that a wrong address shows.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rd_value_out <= 8'h00;
      for (int i = 0; i < 64; i++) begin
        io_q[i] <= 8'h5A ^ 8'(i);
      end
    end else begin
      if (preload_in) begin
        rd_value_out <= preload_value_in;
      end else if (rd_write_in) begin
        rd_value_out <= rd_result_in;
      end
      if (io_write_in) begin
        io_q[io_write_addr_in] <= io_result_in;
      end
    end
  end

  assign io_value_out = io_q[io_read_addr_in];
endmodule // bsfu_core_model

// >>> testbench.sv
// Self-checking testbench for the bit, shift and flag unit.
`timescale 1ns/1ns
`include "bsfu_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic                       clock_in      = 1'b0;
  logic                       reset_in      = 1'b1;
  logic                       op_valid      = 1'b0;
  bsfu_pkg::bsfu_op_type      op_code       = bsfu_pkg::BSFU_OP_IDLE;
  logic [2:0]                 bit_sel       = 3'h0;
  logic [7:0]                 rr_value      = 8'h00;
  logic [`BSFU_IO_ADDR_W-1:0] io_addr       = 6'h00;
  logic [7:0]                 stack_byte    = 8'h00;
  logic                       status_load   = 1'b0;
  logic [7:0]                 status_value  = 8'h00;
  logic                       preload       = 1'b0;
  logic [7:0]                 preload_value = 8'h00;
  logic [7:0]                 rd_value, io_value, rd_result, io_result, status;
  logic [`BSFU_IO_ADDR_W-1:0] io_addr_q;
  logic                       rd_write, io_write, done;
  logic [7:0]                 exp_st        = 8'h00;
  int                         n_mismatch    = 0;
  int                         compares      = 0;
  int                         cycles        = 0;

  always #4 clock_in = ~clock_in;

  bsfu_unit u_bsfu_unit (.clock_in(clock_in), .reset_in(reset_in), .op_valid_in(op_valid), .op_code_in(op_code),
    .bit_sel_in(bit_sel), .rd_value_in(rd_value), .rr_value_in(rr_value), .io_addr_in(io_addr),
    .io_value_in(io_value), .stack_byte_in(stack_byte), .status_load_in(status_load),
    .status_value_in(status_value), .rd_result_out(rd_result), .rd_write_out(rd_write), .io_addr_out(io_addr_q),
    .io_result_out(io_result), .io_write_out(io_write), .status_out(status), .done_out(done));

  bsfu_core_model u_bsfu_core_model (.clock_in(clock_in), .reset_in(reset_in), .preload_in(preload),
    .preload_value_in(preload_value), .rd_write_in(rd_write), .rd_result_in(rd_result), .io_write_in(io_write),
    .io_write_addr_in(io_addr_q), .io_result_in(io_result), .io_read_addr_in(io_addr), .rd_value_out(rd_value),
    .io_value_out(io_value));

  // ----------------------------------------------------------------------------
  // Shared drivers
  // ----------------------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // Issues one operation and returns once its write-back has landed in the model.
  task automatic do_op(input bsfu_pkg::bsfu_op_type op, input logic [2:0] b, input logic wr_rd, input logic wr_io);
    @(posedge clock_in);
    op_valid <= 1'b1;
    op_code  <= op;
    bit_sel  <= b;
    @(posedge clock_in);
    op_valid <= 1'b0;
    #1;
    `CHK(done, 1'b1)
    `CHK(rd_write, wr_rd)
    `CHK(io_write, wr_io)
    @(posedge clock_in);
    #1;
  endtask

  task automatic load_rd(input logic [7:0] v);
    @(posedge clock_in);
    preload       <= 1'b1;
    preload_value <= v;
    @(posedge clock_in);
    preload       <= 1'b0;
  endtask

  function automatic logic [8:0] shift_ref(input bsfu_pkg::bsfu_op_type op, input logic [7:0] v, input logic c);
    case (op)
      bsfu_pkg::BSFU_OP_LOGICAL_LEFT_SHIFT:  shift_ref = {v[7], v[6:0], 1'b0};
      bsfu_pkg::BSFU_OP_LOGICAL_RIGHT_SHIFT: shift_ref = {v[0], 1'b0, v[7:1]};
      bsfu_pkg::BSFU_OP_ROTATE_LEFT_CARRY:   shift_ref = {v[7], v[6:0], c};
      bsfu_pkg::BSFU_OP_ROTATE_RIGHT_CARRY:  shift_ref = {v[0], c, v[7:1]};
      default:                               shift_ref = {v[0], v[7], v[7:1]};
    endcase
  endfunction

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_io();
    logic [7:0] v;
    for (int b = 0; b < 8; b++) begin
      @(posedge clock_in);
      io_addr <= 6'(b * 7 + 3);
      v = 8'h5A ^ 8'(b * 7 + 3);
      do_op(bsfu_pkg::BSFU_OP_IO_BIT_SET, 3'(b), 1'b0, 1'b1);
      v[b] = 1'b1;
      `CHK(io_addr_q, 6'(b * 7 + 3))
      `CHK(io_result, v)
      do_op(bsfu_pkg::BSFU_OP_IO_BIT_CLEAR, 3'(b), 1'b0, 1'b1);
      v[b] = 1'b0;
      `CHK(io_result, v)
      `CHK(io_value, v)
    end
    `CHK(status, exp_st)
    $display("test io bits done");
  endtask

  // Operands are preloaded one by one; each rotate consumes the carry left by the previous shift or rotate.
  task automatic t_shift();
    bsfu_pkg::bsfu_op_type ops [7] = '{bsfu_pkg::BSFU_OP_LOGICAL_LEFT_SHIFT, bsfu_pkg::BSFU_OP_LOGICAL_RIGHT_SHIFT,
      bsfu_pkg::BSFU_OP_ROTATE_LEFT_CARRY, bsfu_pkg::BSFU_OP_ROTATE_RIGHT_CARRY, bsfu_pkg::BSFU_OP_ARITH_RIGHT_SHIFT,
      bsfu_pkg::BSFU_OP_ROTATE_LEFT_CARRY, bsfu_pkg::BSFU_OP_ROTATE_RIGHT_CARRY};
    logic [7:0] vals [7] = '{8'h81, 8'h81, 8'h80, 8'h01, 8'hC0, 8'h00, 8'h01};
    logic [8:0] r;
    for (int i = 0; i < 7; i++) begin
      load_rd(vals[i]);
      r = shift_ref(ops[i], vals[i], exp_st[`BSFU_FLAG_C]);
      do_op(ops[i], 3'h0, 1'b1, 1'b0);
      exp_st[`BSFU_FLAG_C] = r[8];
      exp_st[`BSFU_FLAG_Z] = (r[7:0] == 8'h00);
      exp_st[`BSFU_FLAG_N] = r[7];
      exp_st[`BSFU_FLAG_V] = r[7] ^ r[8];
      `CHK(rd_result, r[7:0])
      `CHK(status, exp_st)
      `CHK(rd_value, r[7:0])
    end
    $display("test shifts done");
  endtask

  task automatic t_flags();
    bsfu_pkg::bsfu_op_type ops [6] = '{bsfu_pkg::BSFU_OP_CARRY_SET, bsfu_pkg::BSFU_OP_NEGATIVE_SET,
      bsfu_pkg::BSFU_OP_ZERO_SET, bsfu_pkg::BSFU_OP_ZERO_CLEAR, bsfu_pkg::BSFU_OP_CARRY_CLEAR,
      bsfu_pkg::BSFU_OP_NEGATIVE_CLEAR};
    int pos [6] = '{`BSFU_FLAG_C, `BSFU_FLAG_N, `BSFU_FLAG_Z, `BSFU_FLAG_Z, `BSFU_FLAG_C, `BSFU_FLAG_N};
    @(posedge clock_in);
    status_load  <= 1'b1;
    status_value <= 8'hA5;
    @(posedge clock_in);
    status_load  <= 1'b0;
    exp_st = 8'hA5;
    for (int s = 0; s < 8; s++) begin
      do_op(bsfu_pkg::BSFU_OP_STATUS_FLAG_SET, 3'(s), 1'b0, 1'b0);
      exp_st[s] = 1'b1;
      `CHK(status, exp_st)
    end
    for (int s = 0; s < 8; s++) begin
      do_op(bsfu_pkg::BSFU_OP_STATUS_FLAG_CLEAR, 3'(s), 1'b0, 1'b0);
      exp_st[s] = 1'b0;
      `CHK(status, exp_st)
    end
    for (int i = 0; i < 6; i++) begin
      do_op(ops[i], 3'h0, 1'b0, 1'b0);
      exp_st[pos[i]] = (i < 3);
      `CHK(status, exp_st)
    end
    $display("test flags done");
  endtask

  task automatic t_bits();
    @(posedge clock_in);
    rr_value   <= 8'h40;
    stack_byte <= 8'h9E;
    do_op(bsfu_pkg::BSFU_OP_BIT_STORE_TO_FLAG, 3'h6, 1'b0, 1'b0);
    exp_st[`BSFU_FLAG_T] = 1'b1;
    `CHK(status, exp_st)
    load_rd(8'h00);
    do_op(bsfu_pkg::BSFU_OP_FLAG_TO_BIT_LOAD, 3'h3, 1'b1, 1'b0);
    `CHK(rd_result, 8'h08)
    do_op(bsfu_pkg::BSFU_OP_BIT_STORE_TO_FLAG, 3'h5, 1'b0, 1'b0);
    exp_st[`BSFU_FLAG_T] = 1'b0;
    `CHK(status, exp_st)
    do_op(bsfu_pkg::BSFU_OP_FLAG_TO_BIT_LOAD, 3'h3, 1'b1, 1'b0);
    `CHK(rd_result, 8'h00)
    load_rd(8'h3C);
    do_op(bsfu_pkg::BSFU_OP_NIBBLE_SWAP, 3'h0, 1'b1, 1'b0);
    `CHK(rd_result, 8'hC3)
    `CHK(status, exp_st)
    do_op(bsfu_pkg::BSFU_OP_POP, 3'h0, 1'b1, 1'b0);
    `CHK(rd_result, 8'h9E)
    @(posedge clock_in);
    op_valid <= 1'b1;
    op_code  <= bsfu_pkg::BSFU_OP_IDLE;
    @(posedge clock_in);
    op_valid <= 1'b0;
    #1;
    `CHK(done, 1'b0)
    `CHK(status, exp_st)
    $display("test bits, swap and pop done");
  endtask

  initial begin
    repeat (20) @(posedge clock_in);
    reset_in <= 1'b0;
    t_io();
    t_shift();
    t_flags();
    t_bits();
    end_sim();
  end
endmodule // testbench
